// ### vwac_dev_model.sv
/* Behavioural word-mode address slice facing the host.
   Assumes the host drives every pin; the slice has no clock. */
`default_nettype none
module vwac_dev_model (
  input wire logic [15:0] bus_i,     // Combined local bus
  input wire logic        oe_i,
  input wire logic        stb_n_i,
  input wire logic        sel_i,
  input wire logic        ie_n_i,
  input wire logic        mreq_n_i,
  input wire logic        breq_n_i,
  input wire logic        le_out_i,
  input wire logic        le_in_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cmp_r, mask_r, hold_r, alt_r;
  logic [15:0] lcnt_r, vcnt_r;  // Address only, no data path
  logic [1:0]  pick_r;          // Register chosen at strobe fall
  logic        word_w;
  logic [15:0] seen_w;
  assign word_w = le_out_i && le_in_i;
  // Released bus reads back inverted, never a stale match
  assign seen_w = oe_i ? bus_i : ~bus_i;
  always @(negedge stb_n_i) begin
    if (!ie_n_i && sel_i) pick_r = 2'h2;
    else if (!mreq_n_i) pick_r = 2'h3;
    else pick_r = {1'b0, sel_i};
  end
  // Capture on strobe rise
  always @(posedge stb_n_i) begin
    if (word_w) begin
      case (pick_r)
        2'h0: mask_r = seen_w;
        2'h1: cmp_r = seen_w;
        2'h2: hold_r = seen_w;
        default: alt_r = seen_w;
      endcase
    end
  end
  // Master first: counter from bus
  always @(negedge breq_n_i) begin
    if (word_w && !mreq_n_i) begin
      vcnt_r = seen_w;
      lcnt_r = hold_r;
    end
  end
  // Block first: counter from alternate latch
  always @(negedge mreq_n_i) begin
    if (word_w && !breq_n_i) begin
      vcnt_r = alt_r;
      lcnt_r = hold_r;
    end
  end
endmodule
`default_nettype wire

// ### vwac_host.sv
/*
  Host controller driving a VMEbus address slice in word width mode.
  Assumes the slice sits off-clock; its pins are driven from flops here.
*/
`default_nettype none
module vwac_host (
  input  wire logic                     core_clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     cmd_valid_i,   // Command request
  input  wire vwac_pkg::vwac_cmd_type   cmd_i,         // Command code
  input  wire logic [15:0]              cmd_addr_i,    // Address payload
  input  wire logic [15:0]              cmd_laddr_i,   // Local addr (BLT)
  output logic                          cmd_ready_o,   // Idle, accepts
  output logic                          cmd_done_o,    // Command finished
  output logic [15:0]                   local_bus_o,   // Local addr bus
  output logic                          local_bus_oe_o,
  output logic                          strobe_n_o,
  output logic                          local_data_select_o,
  output logic                          inbound_enable_n_o,
  output logic                          master_cycle_request_n_o,
  output logic                          block_transfer_request_n_o,
  output logic                          outbound_latch_enable_o,
  output logic                          inbound_latch_enable_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,   // Waiting for command
    ST_SEL,    // Select levels set, strobe high
    ST_LOW,    // Strobe low, data setup
    ST_HOLD,   // Strobe high, hold
    ST_REQ1,   // First request asserted
    ST_REQ2,   // Both requests asserted
    ST_REL,    // Requests released, hold address
    ST_NEXT    // Go on to second cycle of a start
  } vwac_state_type;

  vwac_state_type       state_r;     // Sequencer state
  vwac_pkg::vwac_cmd_type cmd_r;     // Latched command
  logic [15:0]          addr_r;      // VMEbus address payload
  logic [15:0]          laddr_r;     // Local counter payload
  logic                 second_r;    // Second cycle of a start
  logic                 tload;       // Timer start
  logic [3:0]           tcount;      // Timer length
  logic                 tdone;       // Timer elapsed

  vwac_phase_timer u_timer (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (tload),
    .count_i    (tcount),
    .done_o     (tdone)
  );

  // Timer restarts on every state change
  always_comb begin
    tload  = 1'b0;
    tcount = vwac_pkg::PHASE_CYC;
    case (state_r)
      ST_IDLE: tload = cmd_valid_i;
      ST_NEXT: tload = 1'b1;
      ST_REL:  tcount = vwac_pkg::HOLD_CNT;
      default: tload = 1'b0;
    endcase
    if (tdone && state_r != ST_IDLE && state_r != ST_NEXT) begin
      tload = 1'b1;
      if (state_r == ST_LOW || state_r == ST_REQ2) begin
        tcount = vwac_pkg::HOLD_CNT;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Strobe cycles: SEL -> LOW -> HOLD. Starts: REQ1 -> REQ2 -> REL.
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r  <= ST_IDLE;
      cmd_r    <= vwac_pkg::VWAC_CMD_COMPARE;
      addr_r   <= vwac_pkg::BUS_RST;
      laddr_r  <= vwac_pkg::BUS_RST;
      second_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmd_valid_i) begin
            cmd_r    <= cmd_i;
            addr_r   <= cmd_addr_i;
            laddr_r  <= cmd_laddr_i;
            second_r <= 1'b0;
            // A start opens with the latch strobe cycle
            state_r  <= (cmd_i == vwac_pkg::VWAC_CMD_BLT ||
                         cmd_i == vwac_pkg::VWAC_CMD_BLT_REV) ?
                        ST_SEL : ((cmd_i == vwac_pkg::VWAC_CMD_COMPARE ||
                        cmd_i == vwac_pkg::VWAC_CMD_MASK ||
                        cmd_i == vwac_pkg::VWAC_CMD_LOCAL ||
                        cmd_i == vwac_pkg::VWAC_CMD_ALT) ?
                        ST_SEL : ST_IDLE);
          end
        end
        ST_SEL:  if (tdone) state_r <= ST_LOW;
        ST_LOW:  if (tdone) state_r <= ST_HOLD;
        ST_HOLD: if (tdone) begin
          // Local address goes in before the initiation cycle
          if ((cmd_r == vwac_pkg::VWAC_CMD_BLT ||
               cmd_r == vwac_pkg::VWAC_CMD_BLT_REV) && !second_r) begin
            state_r <= ST_NEXT;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_NEXT: begin
          second_r <= 1'b1;
          state_r  <= ST_REQ1;
        end
        ST_REQ1: if (tdone) state_r <= ST_REQ2;
        ST_REQ2: if (tdone) state_r <= ST_REL;
        ST_REL:  if (tdone) state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Word mode straps; the slice has no data mux, so no data pins here
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      outbound_latch_enable_o <= 1'b1;
      inbound_latch_enable_o  <= 1'b1;
    end else begin
      outbound_latch_enable_o <= 1'b1;
      inbound_latch_enable_o  <= 1'b1;
    end
  end

  // Strobe low only in the LOW phase
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      strobe_n_o <= 1'b1;
    end else begin
      strobe_n_o <= !(state_r == ST_SEL && tdone) &&
                    !(state_r == ST_LOW && !tdone);
    end
  end

  // Select levels decode the register; inbound enable replaces request
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      local_data_select_o <= 1'b0;
      inbound_enable_n_o  <= 1'b1;
    end else if (state_r == ST_IDLE || state_r == ST_NEXT) begin
      local_data_select_o <= 1'b0;
      inbound_enable_n_o  <= 1'b1;
    end else if (state_r == ST_SEL) begin
      case (cmd_r)
        vwac_pkg::VWAC_CMD_COMPARE: begin
          local_data_select_o <= 1'b1;
          inbound_enable_n_o  <= 1'b1;
        end
        vwac_pkg::VWAC_CMD_MASK: begin
          local_data_select_o <= 1'b0;
          inbound_enable_n_o  <= 1'b1;
        end
        vwac_pkg::VWAC_CMD_ALT: begin
          local_data_select_o <= 1'b1;
          inbound_enable_n_o  <= 1'b1;
        end
        default: begin
          // Holding latch: select high, inbound enable low
          local_data_select_o <= 1'b1;
          inbound_enable_n_o  <= 1'b0;
        end
      endcase
    end
  end

  // Alternate latch uses the master request pin as its select
  // Starts: normal order asserts master request first
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      master_cycle_request_n_o   <= 1'b1;
      block_transfer_request_n_o <= 1'b1;
    end else begin
      case (state_r)
        ST_SEL: begin
          master_cycle_request_n_o   <= !(cmd_r == vwac_pkg::VWAC_CMD_ALT);
          block_transfer_request_n_o <= 1'b1;
        end
        ST_NEXT: begin
          master_cycle_request_n_o   <=
            (cmd_r == vwac_pkg::VWAC_CMD_BLT_REV);
          block_transfer_request_n_o <=
            (cmd_r != vwac_pkg::VWAC_CMD_BLT_REV);
        end
        ST_REQ1: if (tdone) begin
          master_cycle_request_n_o   <= 1'b0;
          block_transfer_request_n_o <= 1'b0;
        end
        ST_REQ2: if (tdone) begin
          master_cycle_request_n_o   <= 1'b1;
          block_transfer_request_n_o <= 1'b1;
        end
        ST_LOW: begin
          // Hold the select levels through the strobe
        end
        ST_HOLD, ST_REL: begin
        end
        default: begin
          master_cycle_request_n_o   <= 1'b1;
          block_transfer_request_n_o <= 1'b1;
        end
      endcase
    end
  end

  // One 16-bit local bus carries latch value, then full VMEbus address
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      local_bus_o    <= vwac_pkg::BUS_RST;
      local_bus_oe_o <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      local_bus_o    <= vwac_pkg::BUS_RST;
      local_bus_oe_o <= 1'b0;
    end else if (state_r == ST_SEL) begin
      local_bus_oe_o <= 1'b1;
      local_bus_o    <= (cmd_r == vwac_pkg::VWAC_CMD_BLT ||
                         cmd_r == vwac_pkg::VWAC_CMD_BLT_REV) ?
                        laddr_r : addr_r;
    end else if (state_r == ST_NEXT) begin
      local_bus_o    <= addr_r;
      local_bus_oe_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cmd_ready_o <= 1'b0;
      cmd_done_o  <= 1'b0;
    end else begin
      cmd_ready_o <= (state_r == ST_IDLE) && !cmd_valid_i;
      cmd_done_o  <= tdone && ((state_r == ST_REL) ||
                     (state_r == ST_HOLD &&
                      !((cmd_r == vwac_pkg::VWAC_CMD_BLT ||
                         cmd_r == vwac_pkg::VWAC_CMD_BLT_REV) &&
                        !second_r)));
    end
  end
endmodule
`default_nettype wire

// ### vwac_host_checker.sv
/* Pin checker for the word-mode address host.
   Assumes a bind onto vwac_host, one clock domain. */
`default_nettype none
module vwac_host_checker (
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic        cmd_valid_i,
  input wire logic        cmd_ready_o,
  input wire logic        cmd_done_o,
  input wire logic [15:0] local_bus_o,
  input wire logic        local_bus_oe_o,
  input wire logic        strobe_n_o,
  input wire logic        local_data_select_o,
  input wire logic        inbound_enable_n_o,
  input wire logic        master_cycle_request_n_o,
  input wire logic        block_transfer_request_n_o,
  input wire logic        outbound_latch_enable_o,
  input wire logic        inbound_latch_enable_o
);
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // Counter load window: both requests low
  sequence s_both_req;
    !master_cycle_request_n_o && !block_transfer_request_n_o;
  endsequence
  sequence s_stb_fall;
    $fell(strobe_n_o);
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_latch_en_high: assert property (outbound_latch_enable_o &&
    inbound_latch_enable_o) else $error("latch enable low");
  chk_sel_setup: assert property (s_stb_fall |->
    $stable(local_data_select_o) && $stable(inbound_enable_n_o))
    else $error("select moved at strobe fall");
  chk_hold_sel: assert property (!strobe_n_o &&
    !inbound_enable_n_o |-> local_data_select_o)
    else $error("holding latch write without select");
  chk_bus_steady: assert property (!strobe_n_o |->
    local_bus_oe_o && $stable(local_bus_o)) else $error("bus moved");
  chk_strobe_ends: assert property (s_stb_fall |->
    ##[1:8] strobe_n_o) else $error("strobe stuck low");
  chk_load_bus: assert property (s_both_req |->
    local_bus_oe_o && strobe_n_o) else $error("load with bus idle");
  chk_ready_quiet: assert property (cmd_ready_o |-> strobe_n_o &&
    master_cycle_request_n_o && block_transfer_request_n_o)
    else $error("pins busy while ready");
  chk_take_busy: assert property (cmd_ready_o && cmd_valid_i
    |=> !cmd_ready_o) else $error("command not taken");
  chk_done_once: assert property (cmd_done_o |=> !cmd_done_o)
    else $error("done longer than one cycle");
  chk_bus_release: assert property (cmd_done_o |->
    ##[0:2] !local_bus_oe_o) else $error("bus not released");
endmodule
bind vwac_host vwac_host_checker i_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
  .cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o),
  .local_bus_o(local_bus_o), .local_bus_oe_o(local_bus_oe_o),
  .strobe_n_o(strobe_n_o), .local_data_select_o(local_data_select_o),
  .inbound_enable_n_o(inbound_enable_n_o),
  .master_cycle_request_n_o(master_cycle_request_n_o),
  .block_transfer_request_n_o(block_transfer_request_n_o),
  .outbound_latch_enable_o(outbound_latch_enable_o),
  .inbound_latch_enable_o(inbound_latch_enable_o));
`default_nettype wire

// ### vwac_host_tb.sv
/* Self-checking bench for the word-mode address host.
   Assumes the checker is bound and the slice model listens. */
`default_nettype none
module vwac_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  core_clk_i, rstn_i, cmd_valid_i;
  vwac_pkg::vwac_cmd_type cmd_i;
  logic [15:0]           cmd_addr_i, cmd_laddr_i, local_bus_o;
  logic                  cmd_ready_o, cmd_done_o, local_bus_oe_o;
  logic                  strobe_n_o, local_data_select_o;
  logic                  inbound_enable_n_o, master_cycle_request_n_o;
  logic                  block_transfer_request_n_o;
  logic                  outbound_latch_enable_o, inbound_latch_enable_o;
  int                    mismatches, samples_checked;
  always #5 core_clk_i = ~core_clk_i;
  vwac_host i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_addr_i(cmd_addr_i),
    .cmd_laddr_i(cmd_laddr_i), .cmd_ready_o(cmd_ready_o),
    .cmd_done_o(cmd_done_o), .local_bus_o(local_bus_o),
    .local_bus_oe_o(local_bus_oe_o), .strobe_n_o(strobe_n_o),
    .local_data_select_o(local_data_select_o),
    .inbound_enable_n_o(inbound_enable_n_o),
    .master_cycle_request_n_o(master_cycle_request_n_o),
    .block_transfer_request_n_o(block_transfer_request_n_o),
    .outbound_latch_enable_o(outbound_latch_enable_o),
    .inbound_latch_enable_o(inbound_latch_enable_o));
  vwac_dev_model i_dev (.bus_i(local_bus_o), .oe_i(local_bus_oe_o),
    .stb_n_i(strobe_n_o), .sel_i(local_data_select_o),
    .ie_n_i(inbound_enable_n_o), .mreq_n_i(master_cycle_request_n_o),
    .breq_n_i(block_transfer_request_n_o),
    .le_out_i(outbound_latch_enable_o), .le_in_i(inbound_latch_enable_o));
  task automatic check(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One command, waits bounded for ready then done
  task automatic run(input vwac_pkg::vwac_cmd_type c,
                     input logic [15:0] a, input logic [15:0] l);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 40) begin
      @(negedge core_clk_i);
      n++;
    end
    cmd_i = c;
    cmd_addr_i = a;
    cmd_laddr_i = l;
    cmd_valid_i = 1'b1;
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    n = 0;
    while (cmd_done_o !== 1'b1 && n < 60) begin
      @(negedge core_clk_i);
      n++;
    end
    check("done", 16'h1, {15'h0, cmd_done_o});
  endtask
  task automatic t_regs;
    run(vwac_pkg::VWAC_CMD_COMPARE, 16'hffff, 16'h0);
    run(vwac_pkg::VWAC_CMD_MASK, 16'h0001, 16'h0);
    check("compare", 16'hffff, i_dev.cmp_r);
    check("mask", 16'h0001, i_dev.mask_r);
    // Plain holding latch load, outside any block transfer start
    run(vwac_pkg::VWAC_CMD_LOCAL, 16'h5a5a, 16'h0);
    check("hold only", 16'h5a5a, i_dev.hold_r);
    $display("test regs over");
  endtask
  task automatic t_blt;
    run(vwac_pkg::VWAC_CMD_BLT, 16'h8001, 16'h7ffe);
    check("hold", 16'h7ffe, i_dev.hold_r);
    check("vme cnt", 16'h8001, i_dev.vcnt_r);
    check("local cnt", 16'h7ffe, i_dev.lcnt_r);
    repeat (3) @(negedge core_clk_i);
    check("bus oe", 16'h0, {15'h0, local_bus_oe_o});
    $display("test blt over");
  endtask
  task automatic t_rev;
    run(vwac_pkg::VWAC_CMD_ALT, 16'h1234, 16'h0);
    run(vwac_pkg::VWAC_CMD_BLT_REV, 16'hbeef, 16'h00ff);
    check("vme cnt", 16'h1234, i_dev.vcnt_r);
    check("local cnt", 16'h00ff, i_dev.lcnt_r);
    $display("test rev over");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence, reset held 8 cycles
  initial begin
    core_clk_i = 1'b0;
    rstn_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = vwac_pkg::VWAC_CMD_COMPARE;
    cmd_addr_i = 16'h0;
    cmd_laddr_i = 16'h0;
    repeat (8) @(negedge core_clk_i);
    check("rst stb", 16'h1, {15'h0, strobe_n_o});
    check("le", 16'h3, {14'h0, outbound_latch_enable_o,
      inbound_latch_enable_o});
    rstn_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    check("ready", 16'h1, {15'h0, cmd_ready_o});
    $display("test reset over");
    t_regs();
    t_blt();
    t_rev();
    end_of_test();
  end
  // Watchdog at 2000 cycles, far beyond the hundred or so cycles needed
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire

// ### vwac_phase_timer.sv
/*
  Down counter that paces each phase of a pin cycle.
  Assumes the same core clock and synchronous reset as the controller.
*/
`default_nettype none
module vwac_phase_timer (
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       load_i,   // Start a phase
  input  wire logic [3:0] count_i,  // Cycles in the phase
  output logic            done_o    // Phase elapsed (level)
);
  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [3:0] cnt_r;  // Remaining cycles
  // Loads, then counts to zero and stays there
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cnt_r <= 4'h0;
    end else if (load_i) begin
      cnt_r <= count_i;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  // Count only: a load term here would feed back into the load logic
  assign done_o = (cnt_r == 4'h0);
endmodule
`default_nettype wire

// ### vwac_pkg.sv
/*
  Constants shared by the word width address controller host.
  Assumes a 100 MHz core clock and the device strapped to word width mode.
*/
`default_nettype none
package vwac_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;              // Combined word-mode buses
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;       // Core clock period
  localparam int SETUP_NS      = 5;        // Data setup before strobe rise
  localparam int HOLD_NS       = 5;        // Hold after any edge
  localparam int PULSE_NS      = 10;       // Least strobe pulse width
  localparam int SETUP_CYC =
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC  =
    (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC =
    (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PHASE_CYC = 4'(PULSE_CYC + SETUP_CYC);
  localparam logic [3:0] HOLD_CNT  = 4'(HOLD_CYC);
  // ----------------------------------------------------------------
  // Reset values and commands
  // ----------------------------------------------------------------
  localparam logic [15:0] BUS_RST = 16'h0000; // Idle bus value
  // Host commands
  typedef enum logic [2:0] {
    VWAC_CMD_COMPARE,   // Load address compare register
    VWAC_CMD_MASK,      // Load address mask register
    VWAC_CMD_LOCAL,     // Load holding latch (local counter)
    VWAC_CMD_ALT,       // Load alternate VMEbus counter latch
    VWAC_CMD_BLT,       // Block transfer initiation, normal order
    VWAC_CMD_BLT_REV    // Initiation, block request first
  } vwac_cmd_type;
endpackage
`default_nettype wire
